/* File: common/emb_pkg.sv */
// Types shared by the external memory bus design
package emb_pkg;
  // Bus cycle states, Gray coded along idle-setup-strobe-hold
  typedef enum logic [1:0]
  {
    EMB_IDLE   = 2'b00,
    EMB_SETUP  = 2'b01,
    EMB_STROBE = 2'b11,
    EMB_HOLD   = 2'b10
  } emb_state_e;
endpackage : emb_pkg

/* File: common/emb_regs.svh */
// Timing and reset constants for the external memory bus
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define EMB_ADDR_W        16
`define EMB_DATA_W        16
`define EMB_BYTE_W        8
`define EMB_PORT_SEL_RST  1'b0
`define EMB_PORT_DIR_RST  8'h00
`define EMB_PORT_OUT_RST  8'h00
// ----------------------------------------------------------------
// Timing: strobe low time in cycles for zero wait states, and cycles added per wait-state code
// ----------------------------------------------------------------
`define EMB_STROBE_BASE   4'h1
`define EMB_WAIT_STEP     4'h4
`endif

/* File: core/emb_bus.sv */
// External memory bus engine: address, data, selects and strobes
// Overview of operation
// - Low address pins carry address low byte
// - High address pins carry address high byte
// - Address pins usable as GPIO a byte at a time, per-pin direction
// - Address function selected after reset
// - Sixteen data pins move each word
// - Data pins float when bus idle
// - Program select low for program accesses
// - Data select low for data accesses
// - Read strobe low; capture on rise
// - Write strobe low; data driven meanwhile
// - Strobe qualifies address and selects
`timescale 1ns/1ps
`include "emb_regs.svh"
module emb_bus
  import emb_pkg::*;
(
  input  wire logic        mclk,                   // Core clock, 250 MHz
  input  wire logic        rst,                    // Async reset, active high
  // Core side request
  input  wire logic        req_valid,              // Access request
  input  wire logic        req_write,              // 1 write, 0 read
  input  wire logic        req_program,            // 1 program space, 0 data
  input  wire logic [15:0] req_addr,               // Word address
  input  wire logic [15:0] req_wdata,              // Write data
  input  wire logic [1:0]  wait_states,            // 0,4,8,12 extra cycles
  output logic             req_ready,              // Engine idle, takes request
  output logic             rsp_valid,              // Access complete pulse
  output logic [15:0]      rsp_rdata,              // Captured read data
  // Port function control per address byte
  input  wire logic        low_port_sel,           // Low byte as port pins
  input  wire logic [7:0]  low_port_dir,           // Low byte directions
  input  wire logic [7:0]  low_port_out,           // Low byte port outputs
  output logic      [7:0]  low_addr_port_pin_in,   // Low byte sampled pins
  input  wire logic        high_port_sel,          // High byte as port pins
  input  wire logic [7:0]  high_port_dir,          // High byte directions
  input  wire logic [7:0]  high_port_out,          // High byte port outputs
  output logic      [7:0]  high_addr_port_pin_in,  // High byte sampled pins
  // Pins
  input  wire logic [15:0] ext_addr_pins_in,       // Address pin levels
  output logic      [15:0] ext_addr_pins_out,      // Address pin drive
  output logic      [15:0] ext_addr_pins_oe,       // Address pin enables
  input  wire logic [15:0] ext_data_pins_in,       // Data pin levels
  output logic      [15:0] ext_data_pins_out,      // Data pin drive
  output logic      [15:0] ext_data_pins_oe,       // Data pin enables
  output logic             program_space_select_n, // Program select, low
  output logic             data_space_select_n,    // Data select, low
  output logic             read_strobe_n,          // Read strobe, low
  output logic             write_strobe_n          // Write strobe, low
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  emb_state_e  state_reg;    // Bus cycle state
  logic [3:0]  count_reg;    // Strobe cycles remaining
  logic [15:0] addr_reg;     // Latched address
  logic [15:0] wdata_reg;    // Latched write data
  logic        write_reg;    // Latched direction
  logic        prog_reg;     // Latched space
  logic [3:0]  count_next;   // Strobe length for a new access
  logic [15:0] addr_next;    // Address handed to the pin registers
  // Strobe length from wait state code; decoded in one place
  function automatic logic [3:0] strobe_len(input logic [1:0] ws);
    strobe_len = 4'(`EMB_STROBE_BASE + 4'(ws) * `EMB_WAIT_STEP);
  endfunction : strobe_len
  assign count_next = strobe_len(wait_states);
  // Pins get a new address with the selects, a cycle ahead of the strobe
  assign addr_next = (state_reg == EMB_IDLE && req_valid) ? req_addr : addr_reg;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  // Setup and hold cycles keep address and select stable around the
  // strobe edges, so the memory never sees them move under a strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= EMB_IDLE;
      count_reg <= 4'h0;
    end
    else
    begin
      case (state_reg)
        EMB_IDLE:
        begin
          if (req_valid)
          begin
            state_reg <= EMB_SETUP;
            count_reg <= count_next;
          end
        end
        EMB_SETUP:
          state_reg <= EMB_STROBE;
        EMB_STROBE:
        begin
          if (count_reg == 4'h1)
            state_reg <= EMB_HOLD;
          else
            count_reg <= count_reg - 4'h1;
        end
        EMB_HOLD:
          state_reg <= EMB_IDLE;
        default:
          state_reg <= EMB_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Request latch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      write_reg <= 1'b0;
      prog_reg  <= 1'b0;
    end
    else if (state_reg == EMB_IDLE && req_valid)
    begin
      addr_reg  <= req_addr;
      wdata_reg <= req_wdata;
      write_reg <= req_write;
      prog_reg  <= req_program;
    end
  end
  // ----------------------------------------------------------------
  // Space selects and strobes
  // ----------------------------------------------------------------
  // Selects cover setup, strobe and hold; only one ever low
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      program_space_select_n <= 1'b1;
      data_space_select_n    <= 1'b1;
      read_strobe_n          <= 1'b1;
      write_strobe_n         <= 1'b1;
    end
    else
    begin
      // Current state decides next pin levels
      case (state_reg)
        EMB_IDLE:
        begin
          program_space_select_n <= ~(req_valid & req_program);
          data_space_select_n    <= ~(req_valid & ~req_program);
        end
        EMB_SETUP:
        begin
          read_strobe_n  <= write_reg;
          write_strobe_n <= ~write_reg;
        end
        EMB_STROBE:
        begin
          if (count_reg == 4'h1)
          begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
          end
        end
        EMB_HOLD:
        begin
          program_space_select_n <= 1'b1;
          data_space_select_n    <= 1'b1;
        end
        default:
        begin
          program_space_select_n <= 1'b1;
          data_space_select_n    <= 1'b1;
          read_strobe_n          <= 1'b1;
          write_strobe_n         <= 1'b1;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Data pins
  // ----------------------------------------------------------------
  // Write data drives setup to hold; otherwise floated so a read
  // or another bus master never fights the pins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_data_pins_out <= 16'h0000;
      ext_data_pins_oe  <= 16'h0000;
    end
    else if (state_reg == EMB_IDLE && req_valid && req_write)
    begin
      ext_data_pins_out <= req_wdata;
      ext_data_pins_oe  <= 16'hffff;
    end
    else if (state_reg == EMB_HOLD || state_reg == EMB_IDLE)
    begin
      ext_data_pins_oe  <= 16'h0000;
    end
  end
  // Read capture on the strobe's rising edge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rsp_rdata <= 16'h0000;
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= (state_reg == EMB_HOLD);
      if (state_reg == EMB_STROBE && count_reg == 4'h1 && !write_reg)
        rsp_rdata <= ext_data_pins_in;
    end
  end
  // Ready registered: high only in idle with no request taken
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      req_ready <= 1'b1;
    else
      req_ready <= (state_reg == EMB_HOLD) ||
                   (state_reg == EMB_IDLE && !req_valid);
  end

  // ----------------------------------------------------------------
  // Address pins, one shared byte each
  // ----------------------------------------------------------------
  emb_pin_mux u_low
  (
    .mclk      (mclk),
    .rst       (rst),
    .port_sel  (low_port_sel),
    .port_dir  (low_port_dir),
    .port_out  (low_port_out),
    .addr_byte (addr_next[7:0]),
    .pin_in    (ext_addr_pins_in[7:0]),
    .pin_out   (ext_addr_pins_out[7:0]),
    .pin_oe    (ext_addr_pins_oe[7:0]),
    .port_in   (low_addr_port_pin_in)
  );

  emb_pin_mux u_high
  (
    .mclk      (mclk),
    .rst       (rst),
    .port_sel  (high_port_sel),
    .port_dir  (high_port_dir),
    .port_out  (high_port_out),
    .addr_byte (addr_next[15:8]),
    .pin_in    (ext_addr_pins_in[15:8]),
    .pin_out   (ext_addr_pins_out[15:8]),
    .pin_oe    (ext_addr_pins_oe[15:8]),
    .port_in   (high_addr_port_pin_in)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_one_select: assert property (@(posedge mclk) disable iff (rst)
    !(~program_space_select_n && ~data_space_select_n))
    else $error("both space selects low");
  chk_strobe_qual: assert property (@(posedge mclk) disable iff (rst)
    (~read_strobe_n || ~write_strobe_n) |->
      (program_space_select_n != data_space_select_n))
    else $error("strobe without a select");
  chk_one_strobe: assert property (@(posedge mclk) disable iff (rst)
    !(~read_strobe_n && ~write_strobe_n))
    else $error("both strobes low");
  chk_read_float: assert property (@(posedge mclk) disable iff (rst)
    ~read_strobe_n |-> (ext_data_pins_oe == 16'h0000))
    else $error("data driven during read");
  chk_write_drive: assert property (@(posedge mclk) disable iff (rst)
    ~write_strobe_n |-> (ext_data_pins_oe == 16'hffff))
    else $error("data not driven during write");
  chk_idle_float: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EMB_IDLE && program_space_select_n && data_space_select_n)
      |-> (ext_data_pins_oe == 16'h0000))
    else $error("data driven while idle");
  chk_addr_stable: assert property (@(posedge mclk) disable iff (rst)
    (~read_strobe_n && !$past(read_strobe_n)) |->
      $stable(addr_reg) && $stable(program_space_select_n))
    else $error("address moved under strobe");
  chk_prog_sel: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EMB_IDLE && req_valid && req_program) |=>
      ~program_space_select_n ##1 ~program_space_select_n)
    else $error("program select not low");
  chk_data_sel: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EMB_IDLE && req_valid && !req_program) |=>
      ~data_space_select_n ##1 ~data_space_select_n)
    else $error("data select not low");
  chk_addr_pins: assert property (@(posedge mclk) disable iff (rst)
    (!low_port_sel && !high_port_sel && ~read_strobe_n && !$past(read_strobe_n))
      |-> (ext_addr_pins_out == addr_reg))
    else $error("address pins wrong");
endmodule : emb_bus

/* File: core/emb_pin_mux.sv */
// One byte of address pins shared with general-purpose port pins
`timescale 1ns/1ps
`include "emb_regs.svh"
module emb_pin_mux
  import emb_pkg::*;
(
  input  wire logic       mclk,      // Core clock
  input  wire logic       rst,       // Async reset, active high
  input  wire logic       port_sel,  // 1: port function, 0: address
  input  wire logic [7:0] port_dir,  // Per-pin direction, 1 = output
  input  wire logic [7:0] port_out,  // Port output values
  input  wire logic [7:0] addr_byte, // Address byte from the bus engine
  input  wire logic [7:0] pin_in,    // Pin levels
  output logic      [7:0] pin_out,   // Pin drive value
  output logic      [7:0] pin_oe,    // Pin drive enable
  output logic      [7:0] port_in    // Sampled pin levels
);
  // ----------------------------------------------------------------
  // Per-pin output registers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      // Address function drives always; port drives per direction bit
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b1;
        end
        else if (port_sel)
        begin
          pin_out[i] <= port_out[i];
          pin_oe[i]  <= port_dir[i];
        end
        else
        begin
          pin_out[i] <= addr_byte[i];
          pin_oe[i]  <= 1'b1;
        end
      end
      // Input sampling, usable whatever the function
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          port_in[i] <= 1'b0;
        else
          port_in[i] <= pin_in[i];
      end
    end
  endgenerate
endmodule : emb_pin_mux

/* File: test/emb_sram_model.sv */
// Static memory model for program and data space behind the external bus
`timescale 1ns/1ps
module emb_sram_model
(
  input  wire logic [15:0] addr,    // Address pin level
  input  wire logic [15:0] din,     // Data pin level
  input  wire logic        prog_n,  // Program space select, low
  input  wire logic        data_n,  // Data space select, low
  input  wire logic        rd_n,    // Read strobe, low
  input  wire logic        wr_n,    // Write strobe, low
  output logic      [15:0] dout,    // Read data drive value
  output logic             drive    // High while the model drives the data pins
);
  // ----------------------------------------------------------------
  // Storage, one array per space
  // ----------------------------------------------------------------
  logic [15:0] prog_mem [0:65535];  // Program space words
  logic [15:0] data_mem [0:65535];  // Data space words

  // Drive only under an active read strobe with exactly one select,
  // so a double select shows up as a floating bus, not as data
  assign drive = !rd_n && (prog_n != data_n);
  assign dout  = !prog_n ? prog_mem[addr] : data_mem[addr];

  // Write data is taken as the write strobe rises
  always @(posedge wr_n)
  begin
    if (!prog_n && data_n)
      prog_mem[addr] = din;
    else if (!data_n && prog_n)
      data_mem[addr] = din;
  end
endmodule : emb_sram_model

/* File: test/tb_top.sv */
// Self-checking bench for the external memory bus engine
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, rst, req_valid, req_write, req_program, req_ready, rsp_valid;
  logic [15:0] req_addr, req_wdata, rsp_rdata, a_in, a_out, a_oe, d_in, d_out, d_oe;
  logic [1:0]  wait_states;
  logic        lo_sel, hi_sel, ps_n, ds_n, rd_n, wr_n, m_drive;
  logic [7:0]  lo_dir, lo_out, hi_dir, hi_out, lo_pin, hi_pin;
  logic [15:0] ext_lvl, m_dout;     // Level outside pins put on the address pins
  int          miscompares, checks_done;

  // Wires resolved from every driver; released address lines take ext_lvl, released data lines the model's read data, else the pull-up level
  assign a_in = (a_out & a_oe) | (ext_lvl & ~a_oe);
  assign d_in = (|d_oe) ? d_out : (m_drive ? m_dout : 16'hffff);

  emb_bus u_emb_bus (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_program(req_program), .req_addr(req_addr), .req_wdata(req_wdata),
    .wait_states(wait_states), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .low_port_sel(lo_sel), .low_port_dir(lo_dir),
    .low_port_out(lo_out), .low_addr_port_pin_in(lo_pin), .high_port_sel(hi_sel),
    .high_port_dir(hi_dir), .high_port_out(hi_out), .high_addr_port_pin_in(hi_pin),
    .ext_addr_pins_in(a_in), .ext_addr_pins_out(a_out), .ext_addr_pins_oe(a_oe),
    .ext_data_pins_in(d_in), .ext_data_pins_out(d_out), .ext_data_pins_oe(d_oe),
    .program_space_select_n(ps_n), .data_space_select_n(ds_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n));

  emb_sram_model u_emb_sram_model (.addr(a_in), .din(d_in), .prog_n(ps_n), .data_n(ds_n),
    .rd_n(rd_n), .wr_n(wr_n), .dout(m_dout), .drive(m_drive));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Run takes well under 400 cycles; 5000 cycles means a hang
  initial
  begin
    #20000;
    miscompares++;
    summarize();
  end

  task automatic summarize();
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // One access, judged cycle by cycle at the falling edge
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic pg, input logic [15:0] a,
                        input logic [15:0] d, input logic [1:0] ws);
    int k;
    int lo;
    k = 0;
    lo = 0;
    while (req_ready !== 1'b1 && k < 50)
    begin
      @(negedge mclk);
      k++;
    end
    `CHK(req_ready, 1'b1)
    req_valid = 1'b1;
    req_write = wr;
    req_program = pg;
    req_addr = a;
    req_wdata = wr ? d : ~d;           // A read must not echo the write port
    wait_states = ws;
    @(negedge mclk);
    req_valid = 1'b0;
    k = 1;
    while (rsp_valid !== 1'b1 && k < 50)
    begin
      `CHK(req_ready, 1'b0)
      `CHK(ps_n, ~pg)
      `CHK(ds_n, pg)
      if (rd_n === 1'b0 || wr_n === 1'b0)
      begin
        lo++;
        `CHK({rd_n, wr_n}, {wr, ~wr})
        `CHK(d_oe, wr ? 16'hffff : 16'h0000)
        if (wr)
          `CHK(d_out, d)
      end
      // Address stands from the select edge, ahead of the strobe
      if (!lo_sel)
        `CHK(a_out[7:0], a[7:0])
      if (!hi_sel)
        `CHK(a_out[15:8], a[15:8])
      @(negedge mclk);
      k++;
    end
    `CHK(k, 4 * ws + 4)
    `CHK(lo, 4 * ws + 1)
    `CHK({ps_n, ds_n, rd_n, wr_n}, 4'hf)
    `CHK(d_oe, 16'h0000)
    if (!wr)
      `CHK(rsp_rdata, d)
  endtask : access

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Idle state straight after reset
  task automatic scn_reset();
    `CHK(a_oe, 16'hffff)
    `CHK(d_oe, 16'h0000)
    `CHK({ps_n, ds_n, rd_n, wr_n}, 4'hf)
  endtask : scn_reset

  // Same address in both spaces, every wait-state code, boundary addresses
  task automatic scn_spaces();
    logic [15:0] a;
    for (int w = 0; w < 4; w++)
    begin
      a = (w[0]) ? (16'hffff - 16'(w)) : (16'h8000 * 16'(w / 2));
      access(1'b1, 1'b1, a, 16'ha5c3 ^ 16'(w), 2'(w));
      access(1'b1, 1'b0, a, 16'h3c5a ^ 16'(w), 2'(w));
      access(1'b0, 1'b1, a, 16'ha5c3 ^ 16'(w), 2'(w));
      access(1'b0, 1'b0, a, 16'h3c5a ^ 16'(w), 2'(w));
    end
  endtask : scn_spaces

  // Both address bytes as port pins with mixed directions
  task automatic scn_port();
    lo_sel = 1'b1;
    lo_dir = 8'hf0;
    lo_out = 8'h5a;
    hi_sel = 1'b1;
    hi_dir = 8'h0f;
    hi_out = 8'hc3;
    ext_lvl = 16'h9ee3;
    @(negedge mclk);
    @(negedge mclk);
    `CHK(a_oe, 16'h0ff0)
    `CHK({a_out[11:8], a_out[7:4]}, 8'h35)
    `CHK({hi_pin, lo_pin}, 16'h9353)
    hi_sel = 1'b0;
    access(1'b1, 1'b0, 16'h7e01, 16'h0ff0, 2'd0);
    access(1'b0, 1'b0, 16'h7e01, 16'h0ff0, 2'd0);
    `CHK(a_oe, 16'hfff0)
    lo_sel = 1'b0;
    @(negedge mclk);
    `CHK(a_oe, 16'hffff)
    `CHK({rsp_valid, req_ready}, 2'b01)
  endtask : scn_port

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    rst = 1'b1;
    {req_valid, req_write, req_program, lo_sel, hi_sel} = 5'h00;
    {req_addr, req_wdata, wait_states} = 34'h0;
    {lo_dir, lo_out, hi_dir, hi_out} = 32'h0;
    ext_lvl = 16'hffff;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    scn_reset();
    scn_spaces();
    scn_port();
    summarize();
  end
endmodule : tb_top
